// file: logic/psrd_decoder.sv
// Strap ratio decoder: captures straps after hard reset releases and decodes the core clock setup
//
// Implementation choices: strobed register access and the register addresses.
`timescale 1ns/1ns
`include "psrd_regs.svh"

module psrd_decoder (
   // Clock and reset
   input  wire logic                    clock_i,
   input  wire logic                    sys_rst_i,
   // Board straps
   input  wire psrd_pkg::psrd_strap_t   strap_i,
   // Register port
   input  wire logic [3:0]              reg_addr_i,
   input  wire logic [7:0]              reg_wdata_i,
   input  wire logic                    reg_wr_i,
   input  wire logic                    reg_rd_i,
   output logic      [7:0]              reg_rdata_o,
   // Decoded setup to clock generation
   output psrd_pkg::psrd_clk_cfg_t      clk_cfg_o,
   output logic                         primary_pll_sel_o
);
   import psrd_pkg::*;

   typedef enum logic [1:0] {
      PSRD_ST_RESET   = 2'b00,
      PSRD_ST_CAPTURE = 2'b01,
      PSRD_ST_RUN     = 2'b11
   } psrd_state_t;

   psrd_state_t   state_q,  state_d;
   psrd_strap_t   strap_q,  strap_d;
   psrd_clk_cfg_t cfg_q,    cfg_d;
   logic [7:0]    rdata_q,  rdata_d;
   logic          recap_q,  recap_d;

   // Shared strap decode, used for the captured output and status read
   function automatic psrd_clk_cfg_t psrd_decode(input psrd_strap_t s);
      psrd_clk_cfg_t c;
      logic [4:0]    r;
      c = '0;
      r = s.core_bus_ratio;
      c.mode = PSRD_MODE_PLL;
      case (s.vco_band_strap)
         `PSRD_BAND_HIGH: c.band = PSRD_BAND_GE600;
         `PSRD_BAND_LOW:  c.band = PSRD_BAND_LT600;
         default: begin
            c.band          = PSRD_BAND_RSVD;
            c.band_reserved = 1'b1;
         end
      endcase
      if (r == `PSRD_RATIO_OFF0 || r == `PSRD_RATIO_OFF1 || r == `PSRD_RATIO_OFF2) begin
         c.mode      = PSRD_MODE_OFF;
         c.clock_off = 1'b1;
      end else if (r == `PSRD_RATIO_BYP0 || r == `PSRD_RATIO_BYP1) begin
         // Bypass is a manufacturing mode; timing is not guaranteed there
         c.mode           = PSRD_MODE_BYPASS;
         c.bypass         = 1'b1;
         c.bus_one_to_one = 1'b1;
         c.mult_int       = 5'h01;
      end else if (r <= `PSRD_RATIO_HALF_HI) begin
         c.mult_int    = {1'b0, r[4:1]};
         c.mult_half   = r[0];
         // Flagged only; the board is expected to avoid these codes
         c.unsupported = (r <= `PSRD_RATIO_UNSUP_HI);
      end else begin
         c.mult_int = 5'(r - `PSRD_INT_BASE);
      end
      return c;
   endfunction

   // Control sequence: straps are caught in the second cycle after reset releases
   always_comb begin
      state_d = state_q;
      strap_d = strap_q;
      cfg_d   = cfg_q;
      case (state_q)
         PSRD_ST_RESET: begin
            state_d = PSRD_ST_CAPTURE;
         end
         PSRD_ST_CAPTURE: begin
            strap_d = strap_i;
            cfg_d   = psrd_decode(strap_i);
            state_d = PSRD_ST_RUN;
         end
         PSRD_ST_RUN: begin
            if (recap_q) begin
               state_d = PSRD_ST_CAPTURE;
            end
         end
         default: begin
            state_d = PSRD_ST_RESET;
         end
      endcase
   end

   always_ff @(posedge clock_i) begin
      if (sys_rst_i) begin
         state_q <= PSRD_ST_RESET;
         strap_q <= '0;
         cfg_q   <= '0;
      end else begin
         state_q <= state_d;
         strap_q <= strap_d;
         cfg_q   <= cfg_d;
      end
   end

   // Register port
   always_comb begin
      rdata_d = 8'h00;
      recap_d = 1'b0;
      if (reg_wr_i && reg_addr_i == `PSRD_CTRL_OFS) begin
         recap_d = reg_wdata_i[`PSRD_CTRL_RECAP_BIT];
      end
      if (reg_rd_i) begin
         case (reg_addr_i)
            `PSRD_CFG_OFS:  rdata_d = {1'b0, strap_q};
            `PSRD_STAT_OFS: rdata_d = {cfg_q.mult_int, cfg_q.mult_half,
                                       cfg_q.bypass, cfg_q.clock_off};
            default:        rdata_d = 8'h00;
         endcase
      end
   end

   always_ff @(posedge clock_i) begin
      if (sys_rst_i) begin
         rdata_q <= 8'h00;
         recap_q <= 1'b0;
      end else begin
         rdata_q <= rdata_d;
         recap_q <= recap_d;
      end
   end

   assign reg_rdata_o       = rdata_q;
   assign clk_cfg_o         = cfg_q;
   assign primary_pll_sel_o = 1'b1;

endmodule

// file: pkg/psrd_pkg.sv
// Types shared by the strap ratio decoder
package psrd_pkg;

   typedef enum logic [1:0] {
      PSRD_BAND_GE600 = 2'h0,
      PSRD_BAND_LT600 = 2'h1,
      PSRD_BAND_RSVD  = 2'h3
   } psrd_band_t;

   typedef enum logic [1:0] {
      PSRD_MODE_OFF    = 2'h0,
      PSRD_MODE_BYPASS = 2'h1,
      PSRD_MODE_PLL    = 2'h3
   } psrd_mode_t;

   // Decoded clock setup handed to the clock generation logic
   typedef struct packed {
      psrd_mode_t  mode;
      logic        clock_off;
      logic        bypass;
      logic        bus_one_to_one;
      logic [4:0]  mult_int;
      logic        mult_half;
      logic        unsupported;
      psrd_band_t  band;
      logic        band_reserved;
   } psrd_clk_cfg_t;

   // Raw strap capture
   typedef struct packed {
      logic [1:0] vco_band_strap;
      logic [4:0] core_bus_ratio;
   } psrd_strap_t;

endpackage

// file: pkg/psrd_regs.svh
// Offsets, field positions, reset values and strap codes of the strap ratio decoder
`ifndef PSRD_REGS_SVH
`define PSRD_REGS_SVH

// Register map on the plain register port
`define PSRD_CFG_OFS        4'h0
`define PSRD_STAT_OFS       4'h1
`define PSRD_CTRL_OFS       4'h2

// Strap field positions inside the clock select config register
`define PSRD_CFG_RATIO_LSB  0
`define PSRD_CFG_RATIO_MSB  4
`define PSRD_CFG_BAND_LSB   5
`define PSRD_CFG_BAND_MSB   6

// Control register: bit 0 requests a strap re-capture
`define PSRD_CTRL_RECAP_BIT 0
`define PSRD_CTRL_RST       8'h00

// Band strap codes
`define PSRD_BAND_HIGH      2'h0
`define PSRD_BAND_LOW       2'h2

// Ratio strap codes
`define PSRD_RATIO_OFF0     5'h00
`define PSRD_RATIO_OFF1     5'h01
`define PSRD_RATIO_BYP0     5'h02
`define PSRD_RATIO_BYP1     5'h03
`define PSRD_RATIO_HALF_LO  5'h04
`define PSRD_RATIO_HALF_HI  5'h13
`define PSRD_RATIO_INT_LO   5'h14
`define PSRD_RATIO_INT_HI   5'h1E
`define PSRD_RATIO_OFF2     5'h1F
`define PSRD_RATIO_UNSUP_HI 5'h05
`define PSRD_INT_BASE       5'h0A

`endif

// file: tb/psrd_board.sv
// Board strap model: static strap levels, changed only on request
`timescale 1ns/1ns
module psrd_board (
   input  wire logic             clock_i,
   input  wire logic [6:0]       set_i,
   output psrd_pkg::psrd_strap_t strap_o
);
   import psrd_pkg::*;
   // Bypass codes are strapped here only as a manufacturing-style check
   // Frequency limits are the board's duty; the model applies no clock
   always_ff @(posedge clock_i) begin
      // A board never straps the unsupported 2x and 2.5x ratios
      if (!(set_i[4:0] inside {5'h04, 5'h05})) begin
         strap_o <= set_i;
      end
   end
endmodule

// file: tb/psrd_dec_asserts.sv
// Port assertions of the strap decoder
`timescale 1ns/1ns
module psrd_dec_asserts (
   input wire logic                    clock_i,
   input wire logic                    sys_rst_i,
   input wire psrd_pkg::psrd_strap_t   strap_i,
   input wire logic                    reg_rd_i,
   input wire logic [3:0]              reg_addr_i,
   input wire logic [7:0]              reg_rdata_o,
   input wire psrd_pkg::psrd_clk_cfg_t clk_cfg_o,
   input wire logic                    primary_pll_sel_o
);
   import psrd_pkg::*;
   default clocking @(posedge clock_i); endclocking
   default disable iff (sys_rst_i);
   wire [4:0]          r = strap_i.core_bus_ratio;
   wire [1:0]          b = strap_i.vco_band_strap;
   wire psrd_clk_cfg_t c = clk_cfg_o;
   // The drop to zero under reset is not a capture
   sequence s_new; !$past(sys_rst_i) && $changed(c); endsequence
   sequence s_cfg; reg_rd_i && reg_addr_i == 4'h0; endsequence
   property p_band; s_new |-> c.band == (b == 2'h0 ? PSRD_BAND_GE600 : b == 2'h2 ?
      PSRD_BAND_LT600 : PSRD_BAND_RSVD); endproperty
   a_band: assert property (p_band) else $error("band");
   property p_off; s_new |-> c.clock_off == (r < 5'h02 || r == 5'h1F) &&
      (!c.clock_off || c.mult_int == 5'h00); endproperty
   a_off: assert property (p_off) else $error("off");
   property p_byp; s_new |-> c.bypass == (r inside {5'h02, 5'h03}) &&
      (!c.bypass || c.bus_one_to_one); endproperty
   a_byp: assert property (p_byp) else $error("bypass");
   property p_half; s_new ##0 r inside {[5'h04:5'h13]} |->
      c.mult_int == r >> 1 && c.mult_half == r[0]; endproperty
   a_half: assert property (p_half) else $error("half");
   property p_int; s_new ##0 r inside {[5'h14:5'h1E]} |->
      c.mult_int == r - 5'h0A && !c.mult_half; endproperty
   a_int: assert property (p_int) else $error("int");
   property p_mode; s_new |-> c.mode == (c.clock_off ? PSRD_MODE_OFF :
      c.bypass ? PSRD_MODE_BYPASS : PSRD_MODE_PLL); endproperty
   a_mode: assert property (p_mode) else $error("mode");
   property p_cfg; s_cfg |=> reg_rdata_o == {1'b0, $past(strap_i)}; endproperty
   a_cfg: assert property (p_cfg) else $error("cfg");
   property p_idle; !$past(reg_rd_i) |-> reg_rdata_o == 8'h00; endproperty
   a_idle: assert property (p_idle) else $error("idle");
   property p_src; primary_pll_sel_o; endproperty
   a_src: assert property (p_src) else $error("src");
endmodule

// file: tb/testbench.sv
// Testbench: strap sweep with recapture and register reads
`timescale 1ns/1ns
module testbench;
   import psrd_pkg::*;
   logic          clock_i = 0;
   logic          rst = 1;
   logic [6:0]    set = 7'h00;
   psrd_strap_t   strap;
   logic [3:0]    a = 4'h0;
   logic [7:0]    d = 8'h00;
   logic          wr = 0;
   logic          rd = 0;
   logic [7:0]    q;
   psrd_clk_cfg_t cfg;
   int            n_errors = 0;
   int            samples_checked = 0;
   logic [4:0]    r;
   logic [4:0]    mi;
   logic [1:0]    b;
   initial forever #2 clock_i = ~clock_i;
   psrd_board board_u (.clock_i(clock_i), .set_i(set), .strap_o(strap));
   psrd_decoder dut_u (.clock_i(clock_i), .sys_rst_i(rst), .strap_i(strap),
      .reg_addr_i(a), .reg_wdata_i(d), .reg_wr_i(wr), .reg_rd_i(rd),
      .reg_rdata_o(q), .clk_cfg_o(cfg), .primary_pll_sel_o());
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      samples_checked++;
      if (got !== exp) begin
         n_errors++;
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic wrt(input logic [3:0] ad, input logic [7:0] dt);
      @(posedge clock_i);
      a <= ad;
      d <= dt;
      wr <= 1'b1;
      @(posedge clock_i);
      wr <= 1'b0;
   endtask
   task automatic rdc(input logic [3:0] ad, input logic [7:0] exp);
      @(posedge clock_i);
      a <= ad;
      rd <= 1'b1;
      @(posedge clock_i);
      rd <= 1'b0;
      #1 chk(q, exp);
   endtask
   task automatic final_report();
      $display("Checks %0d errors %0d", samples_checked, n_errors);
      if (n_errors == 0 && samples_checked > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask
   initial begin
      repeat (3) @(posedge clock_i);
      rst <= 1'b0;
      for (int i = 0; i < 32; i++) begin
         r = i[4:0];
         b = i[1:0];
         if (r inside {5'h04, 5'h05}) continue;
         @(posedge clock_i);
         set <= {b, r};
         wrt(4'h2, 8'h01);
         repeat (3) @(posedge clock_i);
         mi = (r < 5'h02 || r == 5'h1F) ? 5'h00 : (r < 5'h04) ? 5'h01 :
            (r < 5'h14) ? r >> 1 : r - 5'h0A;
         rdc(4'h0, {1'b0, b, r});
         rdc(4'h1, {mi, r inside {[5'h04:5'h13]} && r[0], r inside {5'h02, 5'h03},
            r < 5'h02 || r == 5'h1F});
         chk(8'(cfg.band), b == 2'h0 ? 8'h00 : b == 2'h2 ? 8'h01 : 8'h03);
         chk({5'h00, cfg.mode, cfg.bus_one_to_one}, {5'h00, (r < 5'h02 || r == 5'h1F) ?
            2'h0 : (r < 5'h04) ? 2'h1 : 2'h3, r inside {5'h02, 5'h03}});
         $display("Code %h done", r);
      end
      wrt(4'h0, 8'hFF);
      rdc(4'h0, {1'b0, b, r});
      rdc(4'hF, 8'h00);
      $display("Register port done");
      final_report();
   end
endmodule
bind psrd_decoder psrd_dec_asserts chk_u (.clock_i, .sys_rst_i, .strap_i, .reg_rd_i,
   .reg_addr_i, .reg_rdata_o, .clk_cfg_o, .primary_pll_sel_o);
